/* File: hw/sbc_bank.v */
// One bank's state tracker and illegal-command detector
`default_nettype none
`include "sbc_regs.vh"
module sbc_bank #(
  parameter TRP   = `SBC_TRP_CYC,
  parameter TRCD  = `SBC_TRCD_CYC,
  parameter TDPL  = `SBC_TDPL_CYC,
  parameter BURST = `SBC_BURST_CYC
) (
  input  wire                    ref_clk,
  input  wire                    sys_rst,
  input  wire                    cmd_vld,
  input  wire [2:0]              cmd,
  input  wire                    hit,
  input  wire                    ap,
  output reg  [`SBC_ST_W-1:0]    state_q,
  output reg                     illegal_q
);
  reg [`SBC_ST_W-1:0]   state_d;
  reg [`SBC_CNT_W-1:0]  cnt_q;
  reg [`SBC_CNT_W-1:0]  cnt_d;
  reg                   ill_d;
  reg                   wap_rec_q;
  reg                   wap_rec_d;
  wire                  done;
  wire                  glob;
  wire                  mine;
  assign done = (cnt_q == `SBC_CNT_ONE) || (cnt_q == `SBC_CNT_ZERO);
  // Refresh and mode-set concern both banks regardless of bank select
  assign glob = cmd_vld && (cmd == `SBC_CMD_REF || cmd == `SBC_CMD_MRS);
  assign mine = cmd_vld && hit;
  always @* begin
    state_d   = state_q;
    cnt_d     = done ? cnt_q : cnt_q - `SBC_CNT_ONE;
    ill_d     = 1'b0;
    wap_rec_d = wap_rec_q;
    case (state_q)
      `SBC_ST_IDLE: begin
        if (mine && cmd == `SBC_CMD_ACT) begin
          state_d = `SBC_ST_RCD;
          cnt_d   = TRCD[`SBC_CNT_W-1:0];
        end
      end
      `SBC_ST_ACTV: begin
        if (mine && cmd == `SBC_CMD_PRE) begin
          state_d = `SBC_ST_PRE;
          cnt_d   = TRP[`SBC_CNT_W-1:0];
        end else if (mine && cmd == `SBC_CMD_WRITE && ap) begin
          state_d   = `SBC_ST_WAP;
          wap_rec_d = 1'b0;
          cnt_d     = BURST[`SBC_CNT_W-1:0];
        end else if (mine && cmd == `SBC_CMD_WRITE) begin
          state_d = `SBC_ST_WREC;
          cnt_d   = TDPL[`SBC_CNT_W-1:0];
        end else if (glob || (mine && cmd == `SBC_CMD_ACT)) begin
          ill_d = 1'b1;
        end
      end
      `SBC_ST_PRE: begin
        // Repeated precharge is a no-op and does not restart the wait
        if (glob || (mine && cmd != `SBC_CMD_PRE && cmd != `SBC_CMD_BST &&
            cmd != `SBC_CMD_NOP)) begin
          ill_d = 1'b1;
        end
        if (done) begin
          state_d = `SBC_ST_IDLE;
        end
      end
      `SBC_ST_RCD: begin
        if (glob || (mine && cmd != `SBC_CMD_BST &&
            cmd != `SBC_CMD_NOP)) begin
          ill_d = 1'b1;
        end
        if (done) begin
          state_d = `SBC_ST_ACTV;
        end
      end
      `SBC_ST_WAP: begin
        if (glob || (mine && cmd != `SBC_CMD_NOP)) begin
          ill_d = 1'b1;
        end
        if (done && !wap_rec_q) begin
          wap_rec_d = 1'b1;
          cnt_d     = TDPL[`SBC_CNT_W-1:0];
        end else if (done) begin
          state_d = `SBC_ST_PRE;
          cnt_d   = TRP[`SBC_CNT_W-1:0];
        end
      end
      `SBC_ST_WREC: begin
        if (mine && cmd == `SBC_CMD_READ) begin
          state_d = `SBC_ST_ACTV;
        end else if (mine && cmd == `SBC_CMD_WRITE) begin
          cnt_d = TDPL[`SBC_CNT_W-1:0];
        end else if (glob || (mine && (cmd == `SBC_CMD_ACT ||
                     cmd == `SBC_CMD_PRE))) begin
          ill_d = 1'b1;
        end else if (done) begin
          state_d = `SBC_ST_ACTV;
        end
      end
      default: begin
        state_d = `SBC_ST_IDLE;
      end
    endcase
  end
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= `SBC_ST_IDLE;
      cnt_q     <= `SBC_CNT_ZERO;
      illegal_q <= 1'b0;
      wap_rec_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      illegal_q <= ill_d;
      wap_rec_q <= wap_rec_d;
    end
  end
endmodule // sbc_bank
`default_nettype wire

/* File: hw/sbc_regs.vh */
// Command encodings, state codes and timing defaults for the bank tracker
`ifndef SBC_REGS_VH
`define SBC_REGS_VH
// Command code {ras_n, cas_n, we_n} with chip select low
`define SBC_CMD_NOP      3'h7
`define SBC_CMD_BST      3'h6
`define SBC_CMD_READ     3'h5
`define SBC_CMD_WRITE    3'h4
`define SBC_CMD_ACT      3'h3
`define SBC_CMD_PRE      3'h2
`define SBC_CMD_REF      3'h1
`define SBC_CMD_MRS      3'h0
// Bank state one-hot codes
`define SBC_ST_W         6
`define SBC_ST_IDLE      6'h01
`define SBC_ST_ACTV      6'h02
`define SBC_ST_PRE       6'h04
`define SBC_ST_RCD       6'h08
`define SBC_ST_WAP       6'h10
`define SBC_ST_WREC      6'h20
// Timing defaults in clock cycles
`define SBC_TRP_CYC      3
`define SBC_TRCD_CYC     3
`define SBC_TDPL_CYC     2
`define SBC_BURST_CYC    4
`define SBC_CNT_W        8
`define SBC_CNT_ZERO     8'h00
`define SBC_CNT_ONE      8'h01
// Settled pin pattern after reset: chip select high, so nothing is taken
`define SBC_PIN_RST      6'h01
`endif

/* File: hw/sbc_top.v */
// Two-bank command decoder and bank state tracker
`default_nettype none
`include "sbc_regs.vh"
module sbc_top #(
  parameter TRP   = `SBC_TRP_CYC,
  parameter TRCD  = `SBC_TRCD_CYC,
  parameter TDPL  = `SBC_TDPL_CYC,
  parameter BURST = `SBC_BURST_CYC
) (
  input  wire                    ref_clk,
  input  wire                    sys_rst,
  input  wire                    cs_n,
  input  wire                    ras_n,
  input  wire                    cas_n,
  input  wire                    we_n,
  input  wire                    bank_select_bit,
  input  wire                    auto_pre,
  output reg  [`SBC_ST_W-1:0]    bank0_state_q,
  output reg  [`SBC_ST_W-1:0]    bank1_state_q,
  output reg                     illegal_cmd_q
);
  // ******************************************************
  // Input capture
  // ******************************************************
  // Pins pass three flops; a change counts when stages two and three agree
  reg  [5:0] s1_q;
  reg  [5:0] s2_q;
  reg  [5:0] s3_q;
  reg  [5:0] held_q;
  wire       cmd_vld;
  wire [2:0] cmd;
  wire [1:0] hit;
  wire [`SBC_ST_W-1:0] st0;
  wire [`SBC_ST_W-1:0] st1;
  wire       ill0;
  wire       ill1;
  reg        new_q;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q   <= `SBC_PIN_RST;
      s2_q   <= `SBC_PIN_RST;
      s3_q   <= `SBC_PIN_RST;
      held_q <= `SBC_PIN_RST;
      new_q  <= 1'b0;
    end else begin
      s1_q  <= {auto_pre, bank_select_bit, ras_n, cas_n, we_n, cs_n};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      new_q <= (s2_q == s3_q) && (s3_q != held_q);
      if (s2_q == s3_q) begin
        held_q <= s3_q;
      end
    end
  end
  // Only a freshly settled command is taken once; repeats need another settled pattern between them
  assign cmd_vld = new_q && !held_q[0];
  assign cmd     = held_q[3:1];
  assign hit     = {held_q[4], !held_q[4]};
  // ******************************************************
  // Bank trackers
  // ******************************************************
  sbc_bank #(.TRP(TRP), .TRCD(TRCD), .TDPL(TDPL), .BURST(BURST)) u_bank0 (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .cmd_vld   (cmd_vld),
    .cmd       (cmd),
    .hit       (hit[0]),
    .ap        (held_q[5]),
    .state_q   (st0),
    .illegal_q (ill0)
  );
  sbc_bank #(.TRP(TRP), .TRCD(TRCD), .TDPL(TDPL), .BURST(BURST)) u_bank1 (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .cmd_vld   (cmd_vld),
    .cmd       (cmd),
    .hit       (hit[1]),
    .ap        (held_q[5]),
    .state_q   (st1),
    .illegal_q (ill1)
  );
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank0_state_q <= `SBC_ST_IDLE;
      bank1_state_q <= `SBC_ST_IDLE;
      illegal_cmd_q <= 1'b0;
    end else begin
      bank0_state_q <= st0;
      bank1_state_q <= st1;
      illegal_cmd_q <= ill0 || ill1;
    end
  end
endmodule // sbc_top
`default_nettype wire

/* File: verification/sbc_top_asserts.sv */
// Port checker for the two-bank command tracker
`default_nettype none
`include "sbc_regs.vh"
module sbc_top_asserts #(
  parameter int TRP  = `SBC_TRP_CYC,
  parameter int TRCD = `SBC_TRCD_CYC
) (
  input wire logic                 ref_clk,
  input wire logic                 sys_rst,
  input wire logic                 cs_n,
  input wire logic [`SBC_ST_W-1:0] bank0_state_q,
  input wire logic [`SBC_ST_W-1:0] bank1_state_q,
  input wire logic                 illegal_cmd_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Two cycles of slack for the state register itself
  localparam int PMAX = TRP + 2;
  localparam int RMAX = TRCD + 2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_wap_exit:
    assert property ($changed(bank0_state_q) && $past(bank0_state_q) ==
      `SBC_ST_WAP |-> bank0_state_q inside {`SBC_ST_WREC, `SBC_ST_PRE})
    else $error("write auto precharge left to a wrong state");
  chk_pre_idle:
    assert property ($rose(bank0_state_q == `SBC_ST_PRE) |->
      ##[1:PMAX] bank0_state_q == `SBC_ST_IDLE)
    else $error("bank0 precharge did not end in idle");
  chk_pre_again:
    assert property ($rose(bank1_state_q == `SBC_ST_PRE) |->
      ##[1:PMAX] bank1_state_q == `SBC_ST_IDLE)
    else $error("bank1 precharge did not end in idle");
  chk_rcd_active:
    assert property ($rose(bank0_state_q == `SBC_ST_RCD) |->
      ##[1:RMAX] bank0_state_q == `SBC_ST_ACTV)
    else $error("row not active after activate delay");
  chk_wrec_exit:
    assert property ($changed(bank0_state_q) && $past(bank0_state_q) ==
      `SBC_ST_WREC |-> bank0_state_q == `SBC_ST_ACTV)
    else $error("write recovery left to a wrong state");
  chk_ill_pulse:
    assert property (illegal_cmd_q |=> !illegal_cmd_q)
    else $error("illegal flag longer than one cycle");
  chk_desel_quiet:
    assert property (cs_n [*8] |-> !illegal_cmd_q)
    else $error("illegal flag during deselect");
  chk_bank_split:
    assert property (!($rose(bank0_state_q == `SBC_ST_RCD) &&
      $rose(bank1_state_q == `SBC_ST_RCD)))
    else $error("one activate opened both banks");
endmodule // sbc_top_asserts
`default_nettype wire

/* File: verification/sbc_ctl_model.sv */
// Memory controller model driving the command pins
`default_nettype none
module sbc_ctl_model (
  input  wire logic ref_clk,
  output var  logic cs_n,
  output var  logic ras_n,
  output var  logic cas_n,
  output var  logic we_n,
  output var  logic bank_select_bit,
  output var  logic auto_pre
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cs_n, ras_n, cas_n, we_n, bank_select_bit, auto_pre} = 6'h3F;
  // Held 4 cycles to clear the input filter; idle pins show the inverse
  task automatic issue(input logic [2:0] c, input logic b, input logic a);
    @(posedge ref_clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
    {bank_select_bit, auto_pre} = {b, a};
    repeat (4) @(posedge ref_clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ~c};
    {bank_select_bit, auto_pre} = {~b, ~a};
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // sbc_ctl_model
`default_nettype wire

/* File: verification/sbc_top_test.sv */
// Self-checking bench for the two-bank command tracker
`default_nettype none
`include "sbc_regs.vh"
module sbc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 ref_clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 ill_q   = 1'b0;
  wire                  cs_n, ras_n, cas_n, we_n, bsel, ap, ill;
  wire [`SBC_ST_W-1:0]  st0, st1;
  int                   n_errors = 0, cmp_count = 0, cyc = 0;
  always #50 ref_clk = ~ref_clk;
  sbc_ctl_model u_ctl (.ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_bit(bsel), .auto_pre(ap));
  // Long timings leave room to hit each state with a command
  sbc_top #(.TRP(40), .TRCD(40), .TDPL(40), .BURST(20)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_bit(bsel), .auto_pre(ap),
    .bank0_state_q(st0), .bank1_state_q(st1), .illegal_cmd_q(ill));
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (ill === 1'b1) ill_q <= 1'b1;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end
  task automatic results;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic b, a, e);
    #1 ill_q = 1'b0;
    u_ctl.issue(c, b, a);
    // Step off the edge so the latched illegal flag is settled when looked at
    #1 chk({5'h00, ill_q}, {5'h00, e});
  endtask
  task automatic wait_st(input logic b, input logic [5:0] e, input int lim);
    int i;
    for (i = 0; i < lim && (b ? st1 : st0) !== e; i++) @(posedge ref_clk) #1;
    chk(b ? st1 : st0, e);
  endtask
  task automatic s_rcd;
    cmd(`SBC_CMD_ACT, 1'b0, 1'b0, 1'b0);
    wait_st(1'b0, `SBC_ST_RCD, 20);
    cmd(`SBC_CMD_ACT, 1'b1, 1'b0, 1'b0);
    cmd(`SBC_CMD_NOP, 1'b0, 1'b0, 1'b0);
    cmd(`SBC_CMD_READ, 1'b0, 1'b0, 1'b1);
    wait_st(1'b0, `SBC_ST_ACTV, 60);
    wait_st(1'b1, `SBC_ST_ACTV, 60);
  endtask
  task automatic s_wap;
    cmd(`SBC_CMD_WRITE, 1'b0, 1'b1, 1'b0);
    wait_st(1'b0, `SBC_ST_WAP, 20);
    cmd(`SBC_CMD_BST, 1'b0, 1'b0, 1'b1);
    wait_st(1'b0, `SBC_ST_PRE, 80);
    wait_st(1'b0, `SBC_ST_IDLE, 60);
  endtask
  task automatic s_pre;
    cmd(`SBC_CMD_PRE, 1'b1, 1'b0, 1'b0);
    wait_st(1'b1, `SBC_ST_PRE, 20);
    cmd(`SBC_CMD_PRE, 1'b1, 1'b0, 1'b0);
    cmd(`SBC_CMD_BST, 1'b1, 1'b0, 1'b0);
    cmd(`SBC_CMD_MRS, 1'b1, 1'b0, 1'b1);
    cmd(`SBC_CMD_ACT, 1'b1, 1'b0, 1'b1);
    // Tight limit: a restarted precharge wait would overrun it
    wait_st(1'b1, `SBC_ST_IDLE, 6);
  endtask
  task automatic s_wrec;
    cmd(`SBC_CMD_ACT, 1'b0, 1'b0, 1'b0);
    wait_st(1'b0, `SBC_ST_ACTV, 60);
    cmd(`SBC_CMD_WRITE, 1'b0, 1'b0, 1'b0);
    wait_st(1'b0, `SBC_ST_WREC, 30);
    cmd(`SBC_CMD_REF, 1'b0, 1'b0, 1'b1);
    cmd(`SBC_CMD_READ, 1'b0, 1'b0, 1'b0);
    // Active long before the recovery time, so the read did it
    wait_st(1'b0, `SBC_ST_ACTV, 2);
    cmd(`SBC_CMD_WRITE, 1'b0, 1'b0, 1'b0);
    cmd(`SBC_CMD_WRITE, 1'b0, 1'b0, 1'b0);
    // Past the first write's recovery, inside the restarted one
    repeat (31) @(posedge ref_clk);
    #1 chk(st0, `SBC_ST_WREC);
    wait_st(1'b0, `SBC_ST_ACTV, 10);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    s_rcd();
    s_wap();
    s_pre();
    s_wrec();
    results();
  end
endmodule // sbc_top_test
bind sbc_top sbc_top_asserts #(.TRP(TRP), .TRCD(TRCD)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .bank0_state_q(bank0_state_q), .bank1_state_q(bank1_state_q),
  .illegal_cmd_q(illegal_cmd_q));
`default_nettype wire
